// ===== logic/led_ctl.v
// Control, fault masking and serial register access of a twelve-channel LED driver.
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "led_ctl_defines.vh"
module led_ctl (
    // Clock, reset, enable
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        ce,
    // Parallel register port
    input  wire [7:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [7:0]  rdata_r,
    // Serial link pins
    input  wire        sclk,
    input  wire        sdi,
    input  wire        latch,
    output reg         serial_chain_out,
    // Dimming input pins
    input  wire [5:0]  dim_pin,
    // Fault detectors, one-cycle pulses or levels on clk_sys
    input  wire [11:0] gnd_short_det,
    input  wire [11:0] diode_short_det,
    input  wire [11:0] open_det,
    input  wire [5:0]  dim_fault_det,
    input  wire        neighbour_done,
    // Channel and analog controls
    output reg  [11:0] ch_on_r,
    output reg  [95:0] trim_value,
    output reg         off_state_check_disable,
    output reg         neighbour_short_test,
    output reg         slow_edge_select,
    output reg         weak_load_level_select,
    output reg         error_n_r
);
    // ==========================================================
    // Storage
    reg  [11:0] output_disable_bits;
    reg  [35:0] dsel_r;
    reg  [11:0] gnd_suppress_r;
    reg  [11:0] diode_short_suppress;
    reg  [11:0] open_suppress_r;
    reg         alarm_force_r;
    reg         dim_suppress_r;
    reg         err_suppress_r;
    reg  [11:0] short_st_r;
    reg  [11:0] open_st_r;
    reg  [5:0]  dim_st_r;
    reg  [15:0] shift_r;
    reg         sclk_q_d_r;
    reg         latch_q_d_r;

    // Both global suppress bits come up set, so nothing reaches the pin before setup.
    localparam [1:0] global_rst = `RST_GLOBAL;

    wire [8:0]  pin_q;
    wire        sclk_q  = pin_q[0];
    wire        sdi_q   = pin_q[1];
    wire        latch_q = pin_q[2];
    wire [5:0]  dim_q   = pin_q[8:3];

    // Serial link pins and dimming pins come from outside the clock domain.
    // A pin change is seen four to five cycles late, so the host must hold each sclk
    // level for at least two cycles; a faster link clock is not supported.
    pin_sync3 #(.WIDTH(9)) u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .ce      (ce),
        .pin     ({dim_pin, latch, sdi, sclk}),
        .q_r     (pin_q)
    );

    wire sclk_rise  = sclk_q & ~sclk_q_d_r;
    wire latch_rise = latch_q & ~latch_q_d_r;

    // ==========================================================
    // Serial frame decode
    wire [7:0] frame_cmd  = shift_r[15:8];
    wire [7:0] frame_data = shift_r[7:0];
    wire       frame_read = frame_cmd[7];
    wire [7:0] frame_addr = frame_read ? (frame_cmd - `READ_CMD_OFFSET) : frame_cmd;

    // The parallel port wins when both sources act in one cycle.
    wire       ser_wr = latch_rise & ~frame_read;
    wire       ser_rd = latch_rise & frame_read;
    wire       do_wr  = wr | ser_wr;
    wire [7:0] w_addr = wr ? addr : frame_addr;
    wire [7:0] w_data = wr ? wdata : frame_data;
    wire       do_rd  = rd | ser_rd;
    wire [7:0] r_addr = rd ? addr : frame_addr;

    // ==========================================================
    // Read mux shared by both access paths
    function in_trim;
        input [7:0] a;
        begin
            in_trim = (a >= `A_TRIM_FIRST) && (a <= `A_TRIM_LAST);
        end
    endfunction

    function in_dsel;
        input [7:0] a;
        begin
            in_dsel = (a >= `A_DSEL_FIRST) && (a <= `A_DSEL_LAST);
        end
    endfunction

    function [7:0] rd_value;
        input [7:0] a;
        integer k;
        begin
            k = 0;
            rd_value = 8'h00;
            if (in_trim(a)) begin
                k = a - `A_TRIM_FIRST;
                rd_value = trim_value[k*8 +: 8];
            end else if (in_dsel(a)) begin
                k = a - `A_DSEL_FIRST;
                rd_value = {5'h00, dsel_r[k*3 +: 3]};
            end else begin
                case (a)
                    `A_DIS_LO:      rd_value = {2'h0, output_disable_bits[5:0]};
                    `A_DIS_HI:      rd_value = {2'h0, output_disable_bits[11:6]};
                    `A_GND_LO:      rd_value = {2'h0, gnd_suppress_r[5:0]};
                    `A_GND_HI:      rd_value = {2'h0, gnd_suppress_r[11:6]};
                    `A_DIODE_LO:    rd_value = {2'h0, diode_short_suppress[5:0]};
                    `A_DIODE_HI:    rd_value = {2'h0, diode_short_suppress[11:6]};
                    `A_OPEN_LO:     rd_value = {2'h0, open_suppress_r[5:0]};
                    `A_OPEN_HI:     rd_value = {2'h0, open_suppress_r[11:6]};
                    `A_MISC:        rd_value = {3'h0, weak_load_level_select, alarm_force_r,
                                                slow_edge_select, neighbour_short_test,
                                                off_state_check_disable};
                    `A_GLOBAL_MASK: rd_value = {6'h00, err_suppress_r, dim_suppress_r};
                    `A_SHORT_ST_LO: rd_value = {2'h0, short_st_r[5:0]};
                    `A_SHORT_ST_HI: rd_value = {2'h0, short_st_r[11:6]};
                    `A_OPEN_ST_LO:  rd_value = {2'h0, open_st_r[5:0]};
                    `A_OPEN_ST_HI:  rd_value = {2'h0, open_st_r[11:6]};
                    `A_DIM_ST:      rd_value = {2'h0, dim_st_r};
                    default:        rd_value = 8'h00;
                endcase
            end
        end
    endfunction

    // ==========================================================
    // Fault recording: masked faults never reach status.
    wire [11:0] short_set = (gnd_short_det & ~gnd_suppress_r)
                          | (diode_short_det & ~diode_short_suppress);
    wire [11:0] open_set  = open_det & ~open_suppress_r;
    wire [5:0]  dim_set   = dim_suppress_r ? 6'h00 : dim_fault_det;

    reg  [11:0] short_clr;
    reg  [11:0] open_clr;
    reg  [5:0]  dim_clr;

    always @* begin
        short_clr = 12'h000;
        open_clr  = 12'h000;
        dim_clr   = 6'h00;
        if (do_rd) begin
            case (r_addr)
                `A_SHORT_ST_LO: short_clr = 12'h03F;
                `A_SHORT_ST_HI: short_clr = 12'hFC0;
                `A_OPEN_ST_LO:  open_clr  = 12'h03F;
                `A_OPEN_ST_HI:  open_clr  = 12'hFC0;
                `A_DIM_ST:      dim_clr   = 6'h3F;
                default:        short_clr = 12'h000;
            endcase
        end
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            short_st_r <= 12'h000;
            open_st_r  <= 12'h000;
            dim_st_r   <= 6'h00;
        end else if (ce) begin
            // A new event in the clearing cycle survives the read.
            short_st_r <= (short_st_r & ~short_clr) | short_set;
            open_st_r  <= (open_st_r & ~open_clr) | open_set;
            dim_st_r   <= (dim_st_r & ~dim_clr) | dim_set;
        end
    end

    // ==========================================================
    // Configuration registers
    always @(posedge clk_sys) begin
        if (reset) begin
            output_disable_bits     <= `RST_MASK12;
            gnd_suppress_r          <= `RST_MASK12;
            diode_short_suppress    <= `RST_MASK12;
            open_suppress_r         <= `RST_MASK12;
            dim_suppress_r          <= global_rst[`GM_DIM_SUPPRESS];
            err_suppress_r          <= global_rst[`GM_ERR_SUPPRESS];
            trim_value              <= 96'h0;
            dsel_r                  <= 36'h0;
            off_state_check_disable <= 1'b0;
            neighbour_short_test    <= 1'b0;
            slow_edge_select        <= 1'b0;
            alarm_force_r           <= 1'b0;
            weak_load_level_select  <= 1'b0;
        end else if (ce) begin
            // Completion clears the test bit; a write in the same cycle decides.
            if (neighbour_done) begin
                neighbour_short_test <= 1'b0;
            end
            if (do_wr) begin
                if (in_trim(w_addr)) begin
                    trim_value[(w_addr - `A_TRIM_FIRST)*8 +: 8] <= w_data;
                end
                if (in_dsel(w_addr)) begin
                    dsel_r[(w_addr - `A_DSEL_FIRST)*3 +: 3] <= w_data[2:0];
                end
                case (w_addr)
                    `A_DIS_LO:   output_disable_bits[5:0]   <= w_data[5:0];
                    `A_DIS_HI:   output_disable_bits[11:6]  <= w_data[5:0];
                    `A_GND_LO:   gnd_suppress_r[5:0]        <= w_data[5:0];
                    `A_GND_HI:   gnd_suppress_r[11:6]       <= w_data[5:0];
                    `A_DIODE_LO: diode_short_suppress[5:0]  <= w_data[5:0];
                    `A_DIODE_HI: diode_short_suppress[11:6] <= w_data[5:0];
                    `A_OPEN_LO:  open_suppress_r[5:0]       <= w_data[5:0];
                    `A_OPEN_HI:  open_suppress_r[11:6]      <= w_data[5:0];
                    `A_MISC: begin
                        off_state_check_disable <= w_data[`MISC_OFF_CHECK];
                        neighbour_short_test    <= w_data[`MISC_NEIGHBOUR];
                        slow_edge_select        <= w_data[`MISC_SLOW_EDGE];
                        alarm_force_r           <= w_data[`MISC_ALARM_FORCE];
                        weak_load_level_select  <= w_data[`MISC_WEAK_LEVEL];
                    end
                    `A_GLOBAL_MASK: begin
                        dim_suppress_r <= w_data[`GM_DIM_SUPPRESS];
                        err_suppress_r <= w_data[`GM_ERR_SUPPRESS];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Serial shift chain and read-back
    // A read frame replaces the shifted bits, so that frame is not passed down the chain;
    // the host must clock the answer out before it sends the next device its data.
    always @(posedge clk_sys) begin
        if (reset) begin
            shift_r          <= 16'h0000;
            sclk_q_d_r       <= 1'b0;
            latch_q_d_r      <= 1'b0;
            serial_chain_out <= 1'b0;
        end else if (ce) begin
            sclk_q_d_r  <= sclk_q;
            latch_q_d_r <= latch_q;
            if (ser_rd) begin
                // Read data goes out first, ahead of anything shifted behind it.
                shift_r <= {rd_value(frame_addr), 8'h00};
            end else if (sclk_rise) begin
                shift_r <= {shift_r[14:0], sdi_q};
            end
            serial_chain_out <= shift_r[15];
        end
    end

    // ==========================================================
    // Parallel read data, valid in the cycle after the strobe only
    always @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= rd ? rd_value(addr) : 8'h00;
        end
    end

    // ==========================================================
    // Channel gating and error pin
    integer c;

    // Selections beyond the last dimming pin keep the channel dark.
    function dim_gate;
        input [2:0] s;
        input [5:0] pins;
        begin
            dim_gate = 1'b0;
            if (s < `DIM_INPUTS) begin
                dim_gate = pins[s];
            end
        end
    endfunction

    always @(posedge clk_sys) begin
        if (reset) begin
            ch_on_r   <= 12'h000;
            error_n_r <= 1'b1;
        end else if (ce) begin
            for (c = 0; c < `CHANNELS; c = c + 1) begin
                ch_on_r[c] <= ~output_disable_bits[c]
                            & dim_gate(dsel_r[c*3 +: 3], dim_q);
            end
            // Status holds faults that were unmasked when set; one masked later still drives the pin until its status is read.
            error_n_r <= ~(alarm_force_r
                         | (~err_suppress_r
                            & ((|short_st_r) | (|open_st_r) | (|dim_st_r))));
        end
    end
endmodule

// ===== logic/led_ctl_defines.vh
// Register map, field positions and reset values of the LED driver control block.
// Contract
// - Output-disable bit 1 turns channel off.
// - Fault suppress bit 1 masks that fault.
// - Unmasked shorts and opens set status registers.
// - Dimming-fault suppress bit blocks dimming status.
// - Error suppress bit keeps errors off pin.
// - Only unmasked faults may reach error pin; a fault recorded before its mask is set still does until its status is read.
// - Error pin is active low.
// - Off-state check disable bit stops diagnostic.
// - Neighbour-short test self-clears when detection completes.
// - Slow-edge bit selects slow slew rate.
// - Alarm force holds error pin low.
// - Weak-load level bit picks detection threshold.
// - Each channel holds an 8-bit trim value.
// - Per-channel dimming source select field.
// - Miscellaneous command field has five bits.
// - Latch rising edge moves shifted data in.
// - Serial chain output feeds next device.
// - Output-disable writes at 0x52 and 0x53.
// - Output-disable read-back at 0x92 and 0x93.
`ifndef LED_CTL_DEFINES_VH
`define LED_CTL_DEFINES_VH

// ==========================================================
// Register addresses (8-bit index on the parallel port and in serial frames)
`define A_TRIM_FIRST      8'h46
`define A_TRIM_LAST       8'h51
`define A_DIS_LO          8'h52
`define A_DIS_HI          8'h53
`define A_DSEL_FIRST      8'h20
`define A_DSEL_LAST       8'h2B
`define A_GND_LO          8'h5A
`define A_GND_HI          8'h5B
`define A_DIODE_LO        8'h5C
`define A_DIODE_HI        8'h5D
`define A_OPEN_LO         8'h5E
`define A_OPEN_HI         8'h5F
`define A_MISC            8'h60
`define A_GLOBAL_MASK     8'h61
`define A_SHORT_ST_LO     8'h70
`define A_SHORT_ST_HI     8'h71
`define A_OPEN_ST_LO      8'h72
`define A_OPEN_ST_HI      8'h73
`define A_DIM_ST          8'h74

// ==========================================================
// Serial frames: read commands sit this far above the register address
`define READ_CMD_OFFSET   8'h40
`define FRAME_BITS        16

// ==========================================================
// Miscellaneous command field bit positions
`define MISC_OFF_CHECK    0
`define MISC_NEIGHBOUR    1
`define MISC_SLOW_EDGE    2
`define MISC_ALARM_FORCE  3
`define MISC_WEAK_LEVEL   4
`define MISC_WIDTH        5

// Global mask register bit positions
`define GM_DIM_SUPPRESS   0
`define GM_ERR_SUPPRESS   1

// ==========================================================
// Reset values and sizes
`define RST_MASK12        12'hFFF
`define RST_MISC          5'h00
`define RST_GLOBAL        2'h3
`define DSEL_BITS         3
`define DIM_INPUTS        6
`define CHANNELS          12

`endif

// ===== logic/pin_sync3.v
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter WIDTH = 1
) (
    // Clock and control
    input  wire             clk_sys,
    input  wire             reset,
    input  wire             ce,
    // Pins and filtered result
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] q_r
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    integer i;

    always @(posedge clk_sys) begin
        if (reset) begin
            s1_r <= {WIDTH{1'b0}};
            s2_r <= {WIDTH{1'b0}};
            s3_r <= {WIDTH{1'b0}};
            q_r  <= {WIDTH{1'b0}};
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    q_r[i] <= s3_r[i];
                end
            end
        end
    end
endmodule

// ===== verification/led_ctl_properties.sv
// Port-level assertions for the LED driver control block.
`timescale 1ns/1ps
`include "led_ctl_defines.vh"
module led_ctl_properties (
    // Clock and reset
    input logic        clk_sys,
    input logic        reset,
    // Register port
    input logic [7:0]  addr,
    input logic [7:0]  wdata,
    input logic        wr,
    input logic        rd,
    input logic [7:0]  rdata_r,
    // Controls
    input logic        neighbour_done,
    input logic [11:0] ch_on_r,
    input logic [95:0] trim_value,
    input logic        off_state_check_disable,
    input logic        neighbour_short_test,
    input logic        slow_edge_select,
    input logic        weak_load_level_select,
    input logic        error_n_r
);
    // ==========================================================
    // Shadows
    // These bits only move over the parallel port in the bench, so the shadows stay exact.
    logic err_sup_r;
    logic alarm_r;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            err_sup_r <= 1'b1;
            alarm_r   <= 1'b0;
        end else if (wr && addr == `A_GLOBAL_MASK) begin
            err_sup_r <= wdata[`GM_ERR_SUPPRESS];
        end else if (wr && addr == `A_MISC) begin
            alarm_r <= wdata[`MISC_ALARM_FORCE];
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    rdata_idle_a: assert property (!rd |=> rdata_r == 8'h00)
        else $error("read data seen outside its slot");
    misc_write_a: assert property (wr && addr == `A_MISC |=>
        {weak_load_level_select, slow_edge_select, neighbour_short_test, off_state_check_disable}
        == {$past(wdata[4]), $past(wdata[2:0])}) else $error("misc outputs differ from write");
    misc_reserved_a: assert property (rd && addr == `A_MISC |=> rdata_r[7:5] == 3'h0)
        else $error("misc reserved bits not zero");
    neighbour_clear_a: assert property (neighbour_done && neighbour_short_test
        && !(wr && addr == `A_MISC) |=> !neighbour_short_test) else $error("test bit kept");
    dis_off_a: assert property (wr && addr == `A_DIS_LO |-> ##2
        (ch_on_r[5:0] & $past(wdata[5:0], 2)) == 6'h00) else $error("disabled channel on");
    trim_write_a: assert property (wr && addr >= `A_TRIM_FIRST && addr <= `A_TRIM_LAST |=>
        trim_value[($past(addr) - 8'h46) * 8 +: 8] == $past(wdata)) else $error("trim not stored");
    reset_state_a: assert property (disable iff (1'b0) reset |=>
        ch_on_r == 12'h000 && trim_value == 96'h0 && error_n_r) else $error("bad reset state");
    err_masked_a: assert property (err_sup_r && !alarm_r |=> error_n_r)
        else $error("error pin low while suppressed");
    alarm_low_a: assert property (alarm_r |=> !error_n_r)
        else $error("error pin high under alarm force");
    alarm_c: cover property (alarm_r ##1 !error_n_r);
    clear_c: cover property (neighbour_done && neighbour_short_test);
    dis_c: cover property (wr && addr == `A_DIS_HI);
endmodule
bind led_ctl led_ctl_properties u_props (.*);

// ===== verification/host_link_model.sv
// Behavioural host that shifts frames into the block and latches them.
`timescale 1ns/1ps
module host_link_model #(
    parameter int HALF_NS = 32
) (
    // Link pins
    output logic sclk,
    output logic sdi,
    output logic latch,
    input  logic serial_chain_out
);
    initial begin
        sclk  = 1'b0;
        sdi   = 1'b0;
        latch = 1'b0;
    end
    task automatic shift16(input logic [15:0] f, output logic [15:0] got);
        #3;
        for (int i = 15; i >= 0; i--) begin
            sdi = f[i];
            #(HALF_NS);
            got[i] = serial_chain_out;
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
        end
        // The line is not held after a frame, so a stale bit never looks valid.
        sdi = ~sdi;
    endtask
    task automatic pulse_latch();
        #(HALF_NS);
        latch = 1'b1;
        #(2 * HALF_NS);
        latch = 1'b0;
        #(2 * HALF_NS);
    endtask
endmodule

// ===== verification/led_ctl_tb_top.sv
// Self-checking bench for the LED driver control block.
`timescale 1ns/1ps
`include "led_ctl_defines.vh"
module led_ctl_tb_top;
    logic        clk_sys, reset, ce, wr, rd, sclk, sdi, latch, serial_chain_out;
    logic        neighbour_done, error_n_r, off_state_check_disable, neighbour_short_test;
    logic        slow_edge_select, weak_load_level_select;
    logic [7:0]  addr, wdata, rdata_r, v, d;
    logic [5:0]  dim_pin, dim_fault_det;
    logic [11:0] gnd_short_det, diode_short_det, open_det, ch_on_r, dis;
    logic [35:0] sel;
    logic [95:0] trim_value, trim;
    logic [15:0] got;
    integer      seed = 32'h3B34EC8F;
    int          n_errors = 0;
    int          samples_checked = 0;

    led_ctl uut (.*);
    host_link_model #(.HALF_NS(32)) host (.*);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // ==========================================================
    // Helpers
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] dv);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= dv;
        wr    <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1;
        check(rdata_r, exp);
    endtask
    task automatic pulse(input int k, input logic [11:0] b);
        @(posedge clk_sys);
        case (k)
            0: gnd_short_det <= b;
            1: diode_short_det <= b;
            2: open_det <= b;
            default: dim_fault_det <= b[5:0];
        endcase
        @(posedge clk_sys);
        {gnd_short_det, diode_short_det, open_det, dim_fault_det} <= 42'h0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic fault_case(input int k, input logic [7:0] sup_a, input logic [7:0] st_a);
        logic [11:0] b;
        b = 12'($random(seed)) | 12'h041;
        reg_wr(sup_a, 8'h00);
        pulse(k, b);
        repeat (4) @(posedge clk_sys);
        rd_chk(st_a, {2'b00, b[5:0]});
        rd_chk(st_a, 8'h00);
        rd_chk(st_a + 8'h01, 8'h00);
        reg_wr(sup_a, 8'h3F);
    endtask
    function automatic logic [11:0] exp_on(input logic [11:0] ds, input logic [35:0] sl,
                                           input logic [5:0] dm);
        logic [2:0] s;
        for (int n = 0; n < 12; n++) begin
            s = sl[3*n +: 3];
            exp_on[n] = !ds[n] && s < 3'd6 && dm[s];
        end
    endfunction
    // ==========================================================
    // Main sequence
    initial begin
        {reset, ce} = 2'b11;
        {wr, rd, neighbour_done, addr, wdata, dim_pin} = 0;
        {gnd_short_det, diode_short_det, open_det, dim_fault_det} = 42'h0;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 2; i++) rd_chk(`A_DIS_LO + 8'(i), 8'h3F);
        for (int i = 0; i < 6; i++) rd_chk(`A_GND_LO + 8'(i), 8'h3F);
        rd_chk(`A_GLOBAL_MASK, 8'h03);
        rd_chk(8'hFF, 8'h00);
        check(trim_value, 96'h0);
        for (int n = 0; n < 12; n++) begin
            d = (n == 0) ? 8'hFF : 8'($random(seed));
            trim[8*n +: 8] = d;
            reg_wr(`A_TRIM_FIRST + 8'(n), d);
            rd_chk(`A_TRIM_FIRST + 8'(n), d);
            sel[3*n +: 3] = 3'($random(seed));
            reg_wr(`A_DSEL_FIRST + 8'(n), {5'h00, sel[3*n +: 3]});
        end
        check(trim_value, trim);
        for (int r = 0; r < 6; r++) begin
            dis = (r == 0) ? 12'h000 : 12'($random(seed));
            reg_wr(`A_DIS_LO, {2'b00, dis[5:0]});
            reg_wr(`A_DIS_HI, {2'b00, dis[11:6]});
            dim_pin <= 6'($random(seed));
            repeat (8) @(posedge clk_sys);
            #1;
            check(ch_on_r, exp_on(dis, sel, dim_pin));
        end
        fault_case(0, `A_GND_LO, `A_SHORT_ST_LO);
        fault_case(1, `A_DIODE_LO, `A_SHORT_ST_LO);
        fault_case(2, `A_OPEN_LO, `A_OPEN_ST_LO);
        reg_wr(`A_GLOBAL_MASK, 8'h02);
        pulse(3, 12'h02A);
        rd_chk(`A_DIM_ST, 8'h2A);
        check(error_n_r, 1'b1);
        reg_wr(`A_GLOBAL_MASK, 8'h01);
        pulse(3, 12'h015);
        check(error_n_r, 1'b1);
        rd_chk(`A_DIM_ST, 8'h00);
        reg_wr(`A_OPEN_HI, 8'h00);
        pulse(2, 12'h800);
        check(error_n_r, 1'b0);
        rd_chk(`A_OPEN_ST_HI, 8'h20);
        repeat (2) @(posedge clk_sys);
        check(error_n_r, 1'b1);
        for (int i = 0; i < 5; i++) begin
            v = 8'h01 << i;
            reg_wr(`A_MISC, v);
            rd_chk(`A_MISC, v);
            check({weak_load_level_select, slow_edge_select, neighbour_short_test,
                   off_state_check_disable}, {v[4], v[2:0]});
            check(error_n_r, i != 3);
        end
        reg_wr(`A_MISC, 8'hF2);
        @(posedge clk_sys);
        neighbour_done <= 1'b1;
        @(posedge clk_sys);
        neighbour_done <= 1'b0;
        rd_chk(`A_MISC, 8'h10);
        reg_wr(`A_MISC, 8'h00);
        v = 8'($random(seed)) & 8'h3F;
        host.shift16({`A_DIS_LO, v}, got);
        host.pulse_latch();
        rd_chk(`A_DIS_LO, v);
        host.shift16({`A_DIS_HI, ~v & 8'h3F}, got);
        host.pulse_latch();
        host.shift16(16'h9200, got);
        host.pulse_latch();
        host.shift16(16'h9300, got);
        check(got[15:8], v);
        host.pulse_latch();
        host.shift16(16'h0000, got);
        check(got[15:8], ~v & 8'h3F);
        final_report();
    end
    initial begin
        #200000;
        n_errors++;
        final_report();
    end
endmodule
